// file: iegate_pkg.sv
/*
  Package for the interrupt enable gating block: register offsets, field
  positions, reset values and the packed carriers shared by both modules.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package iegate_pkg;

  // Source, unused and global bit positions inside the enable register, and the source count
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_TMR0 = 1;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_TMR1 = 3;
  localparam int unsigned SRC_SER = 4;
  localparam int unsigned SRC_TMR2 = 5;
  localparam int unsigned BIT_UNUSED = 6;
  localparam int unsigned BIT_GLOBAL = 7;
  localparam int unsigned NSRC = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE = 8'ha8;
  localparam logic [7:0] OFS_CTRL = 8'hb8;
  localparam logic [7:0] OFS_REQ = 8'hc0;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hc4;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hc8;

  // Control register fields
  localparam int unsigned CTRL_PRIO_STOP = 7;
  localparam int unsigned CTRL_EXT0_EDGE = 0;

  // Reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] MASK_RST = 6'h00;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic global_int_allow;
    logic unused_one;
    logic tmr2_allow;
    logic serial_port_allow;
    logic tmr1_allow;
    logic ext_line1_allow;
    logic tmr0_allow;
    logic ext_line0_allow;
  } iegate_enable_t;

  typedef struct packed {
    logic [5:0] req;
    logic priority_logic_stop;
  } iegate_gate_in_t;

endpackage

// file: iegate_gate.sv
/*
  Combinational-then-registered gating of the six request lines by the
  global and per-source enable bits. Assumes requests arrive on CLK_I.
*/
`timescale 1ns/10ps
module iegate_gate (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire iegate_pkg::iegate_enable_t en_i,
  input wire iegate_pkg::iegate_gate_in_t gin_i,
  output logic [5:0] pass_o,
  output logic bypass_o
);
  logic [5:0] pass_d;
  logic [5:0] allow;

  always_comb begin
    allow = {en_i.tmr2_allow, en_i.serial_port_allow, en_i.tmr1_allow,
             en_i.ext_line1_allow, en_i.tmr0_allow, en_i.ext_line0_allow};
    // Global bit overrides all per-source bits
    if (!en_i.global_int_allow) begin
      pass_d = 6'h00;
    end else begin
      pass_d = gin_i.req & allow;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pass_o <= 6'h00;
      bypass_o <= 1'b0;
    end else begin
      pass_o <= pass_d;
      bypass_o <= gin_i.priority_logic_stop;
    end
  end

  property p_global_off;
    @(posedge clk_i) disable iff (rst_i)
      !en_i.global_int_allow |=> pass_o == 6'h00;
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("request passed with global enable low");

  property p_src_block;
    @(posedge clk_i) disable iff (rst_i)
      en_i.global_int_allow |=> pass_o == $past(gin_i.req & allow);
  endproperty
  a_src_block: assert property (p_src_block)
    else $error("per-source gating mismatch");

  property p_no_pass_disabled;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (pass_o & ~$past(allow)) == 6'h00;
  endproperty
  a_no_pass_disabled: assert property (p_no_pass_disabled)
    else $error("disabled source passed");
endmodule

// file: iegate_top.sv
/*
  Interrupt enable gating with AXI4-Lite register access. Holds the enable
  register, a control register with the priority stop and external line 0
  edge-mode bits, the external line 0 request flag, and a sticky event
  status with mask driving one level interrupt. Assumes raw source request
  pins are asynchronous and a service pulse comes from the core sequencer.
*/
`timescale 1ns/10ps

module iegate_top (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // AXI4-Lite write address
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  // AXI4-Lite write data
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  // AXI4-Lite read address
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  // AXI4-Lite read data
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Interrupt sources, asynchronous
  input wire logic EXT_LINE0_PIN_I,
  input wire logic [5:0] SRC_REQ_I,
  // Core sequencer
  input wire logic EXT0_SERVICED_I,
  output logic [5:0] CORE_REQ_O,
  output logic PRIO_BYPASS_O,
  // Interrupt out
  output logic IRQ_O
);
  // Sync stages for asynchronous inputs
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic ext0_prev_q;

  iegate_pkg::iegate_enable_t en_q, en_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic ext0_flag_q, ext0_flag_d;
  logic [5:0] stat_q, stat_d;
  logic [5:0] mask_q, mask_d;
  logic irq_q, irq_d;

  // Bus state
  logic aw_full_q, aw_full_d;
  logic w_full_q, w_full_d;
  logic [7:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  logic [5:0] req_now;
  logic [5:0] pass;
  logic bypass;
  logic do_wr;
  logic ext0_rise;
  iegate_pkg::iegate_gate_in_t gin;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == iegate_pkg::OFS_ENABLE) || (a == iegate_pkg::OFS_CTRL)
           || (a == iegate_pkg::OFS_REQ) || (a == iegate_pkg::OFS_IRQ_STAT)
           || (a == iegate_pkg::OFS_IRQ_MASK);
  endfunction

  // Enable register as read: bit 6 forced high
  function automatic logic [31:0] read_word(input logic [7:0] a);
    read_word = 32'h0000_0000;
    case (a)
      iegate_pkg::OFS_ENABLE: begin
        read_word[7:0] = en_q;
        read_word[iegate_pkg::BIT_UNUSED] = 1'b1;
      end
      iegate_pkg::OFS_CTRL: read_word[7:0] = ctrl_q;
      iegate_pkg::OFS_REQ: read_word[0] = ext0_flag_q;
      iegate_pkg::OFS_IRQ_STAT: read_word[5:0] = stat_q;
      iegate_pkg::OFS_IRQ_MASK: read_word[5:0] = mask_q;
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      ext0_prev_q <= 1'b0;
    end else begin
      sync1_q <= {EXT_LINE0_PIN_I, SRC_REQ_I};
      sync2_q <= sync1_q;
      ext0_prev_q <= sync2_q[6];
    end
  end

  assign ext0_rise = sync2_q[6] & ~ext0_prev_q;
  assign do_wr = aw_full_q && w_full_q && !bvalid_q;

  // Line 0 request comes from the flag, others from the synchronised source lines
  always_comb begin
    req_now = sync2_q[5:0];
    req_now[iegate_pkg::SRC_EXT0] = ext0_flag_q;
    gin.req = req_now;
    gin.priority_logic_stop = ctrl_q[iegate_pkg::CTRL_PRIO_STOP];
  end

  iegate_gate u_gate (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .en_i(en_q),
    .gin_i(gin),
    .pass_o(pass),
    .bypass_o(bypass)
  );

  // Bus channel state
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d = w_full_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (S_AXI_AWVALID_I && !aw_full_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !w_full_q) begin
      w_full_d = 1'b1;
      w_data_d = S_AXI_WDATA_I;
      if (!S_AXI_WSTRB_I[0]) begin
        // Only lane 0 carries register bits; without it zeros are written
        w_data_d = 32'h0000_0000;
      end
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_ok(aw_addr_q) ? iegate_pkg::RESP_OKAY
                                   : iegate_pkg::RESP_SLVERR;
    end else if (bvalid_q && S_AXI_BREADY_I) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q) begin
      if (S_AXI_RREADY_I) begin
        rvalid_d = 1'b0;
      end
    end else if (S_AXI_ARVALID_I) begin
      rvalid_d = 1'b1;
      rdata_d = read_word(S_AXI_ARADDR_I);
      rresp_d = addr_ok(S_AXI_ARADDR_I) ? iegate_pkg::RESP_OKAY
                                        : iegate_pkg::RESP_SLVERR;
    end
  end

  // Register file and interrupt state
  always_comb begin
    en_d = en_q;
    ctrl_d = ctrl_q;
    ext0_flag_d = ext0_flag_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (do_wr) begin
      case (aw_addr_q)
        iegate_pkg::OFS_ENABLE: begin
          en_d = w_data_q[7:0];
          en_d.unused_one = 1'b0;
        end
        iegate_pkg::OFS_CTRL: ctrl_d = w_data_q[7:0];
        iegate_pkg::OFS_REQ: begin
          // Software may touch the flag only in edge mode
          if (ctrl_q[iegate_pkg::CTRL_EXT0_EDGE]) begin
            ext0_flag_d = w_data_q[0];
          end
        end
        iegate_pkg::OFS_IRQ_STAT: stat_d = stat_q & ~w_data_q[5:0];
        iegate_pkg::OFS_IRQ_MASK: mask_d = w_data_q[5:0];
        default: ;
      endcase
    end
    // Line 0: level mode follows pin, edge mode latches and clears on service
    if (!ctrl_q[iegate_pkg::CTRL_EXT0_EDGE]) begin
      ext0_flag_d = sync2_q[6];
    end else begin
      if (EXT0_SERVICED_I) begin
        ext0_flag_d = 1'b0;
      end
      if (ext0_rise) begin
        ext0_flag_d = 1'b1;
      end
    end
    // Passed requests are events; set wins over clear
    stat_d = stat_d | pass;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      en_q <= iegate_pkg::ENABLE_RST;
      ctrl_q <= iegate_pkg::CTRL_RST;
      ext0_flag_q <= 1'b0;
      stat_q <= 6'h00;
      mask_q <= iegate_pkg::MASK_RST;
      irq_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      bvalid_q <= 1'b0;
      bresp_q <= iegate_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= iegate_pkg::RESP_OKAY;
    end else begin
      en_q <= en_d;
      ctrl_q <= ctrl_d;
      ext0_flag_q <= ext0_flag_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  assign S_AXI_AWREADY_O = !aw_full_q;
  assign S_AXI_WREADY_O = !w_full_q;
  assign S_AXI_ARREADY_O = !rvalid_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign CORE_REQ_O = pass;
  assign PRIO_BYPASS_O = bypass;
  assign IRQ_O = irq_q;

  property p_bit6_reads_one;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (S_AXI_ARVALID_I && !rvalid_q
       && S_AXI_ARADDR_I == iegate_pkg::OFS_ENABLE)
      |=> S_AXI_RDATA_O[iegate_pkg::BIT_UNUSED];
  endproperty
  a_bit6_reads_one: assert property (p_bit6_reads_one)
    else $error("unused enable bit read as zero");

  property p_tmr0_bit;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (en_q[iegate_pkg::BIT_GLOBAL] && !en_q[iegate_pkg::SRC_TMR0])
      |=> !CORE_REQ_O[iegate_pkg::SRC_TMR0];
  endproperty
  a_tmr0_bit: assert property (p_tmr0_bit)
    else $error("timer 0 passed while disabled");

  property p_ext1_bit;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (en_q[iegate_pkg::BIT_GLOBAL] && en_q[iegate_pkg::SRC_EXT1]
       && sync2_q[iegate_pkg::SRC_EXT1])
      |=> CORE_REQ_O[iegate_pkg::SRC_EXT1];
  endproperty
  a_ext1_bit: assert property (p_ext1_bit)
    else $error("external line 1 not passed while enabled");

  property p_tmr2_bit;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (en_q[iegate_pkg::BIT_GLOBAL] && en_q[iegate_pkg::SRC_TMR2]
       && sync2_q[iegate_pkg::SRC_TMR2])
      |=> CORE_REQ_O[iegate_pkg::SRC_TMR2];
  endproperty
  a_tmr2_bit: assert property (p_tmr2_bit)
    else $error("timer 2 not passed while enabled");

  property p_ser_bit;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      (en_q[iegate_pkg::BIT_GLOBAL] && !en_q[iegate_pkg::SRC_SER])
      |=> !CORE_REQ_O[iegate_pkg::SRC_SER];
  endproperty
  a_ser_bit: assert property (p_ser_bit)
    else $error("serial source passed while disabled");

  sequence s_ext0_service;
    ctrl_q[iegate_pkg::CTRL_EXT0_EDGE] && EXT0_SERVICED_I && !ext0_rise
    && !do_wr;
  endsequence
  property p_ext0_clear;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      s_ext0_service |=> !ext0_flag_q;
  endproperty
  a_ext0_clear: assert property (p_ext0_clear)
    else $error("line 0 flag not cleared on service");

  property p_bypass;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      ctrl_q[iegate_pkg::CTRL_PRIO_STOP] |=> PRIO_BYPASS_O;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("priority bypass not raised");

  property p_global_zero;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      !en_q[iegate_pkg::BIT_GLOBAL] ##1 !en_q[iegate_pkg::BIT_GLOBAL]
      |-> CORE_REQ_O == 6'h00 ##1 (stat_q & ~$past(stat_q)) == 6'h00;
  endproperty
  a_global_zero: assert property (p_global_zero)
    else $error("request seen with global enable low");

  property p_own_bit;
    @(posedge CLK_I) disable iff (SYS_RST_I)
      en_q[iegate_pkg::BIT_GLOBAL]
      |=> CORE_REQ_O == ($past(req_now) & $past(en_q[5:0]));
  endproperty
  a_own_bit: assert property (p_own_bit)
    else $error("request does not follow its own enable");
endmodule

// file: iegate_core_model.sv
/*
  Core sequencer stand-in: services external line 0 when its gated
  request has stood for a chosen number of cycles. Assumes one clock.
*/
`timescale 1ns/10ps
module iegate_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Gated requests and service latency
  input wire logic [5:0] req_i,
  input wire logic [3:0] lat_i,
  // Service pulse
  output logic ext0_serviced_o
);
  logic [3:0] cnt_q;
  // Latency restarts after each pulse, so a fast core pulses again
  always_ff @(posedge clk_i) begin
    ext0_serviced_o <= 1'b0;
    if (rst_i || !req_i[0]) begin
      cnt_q <= 4'h0;
    end else if (cnt_q == lat_i) begin
      ext0_serviced_o <= 1'b1;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// file: tb.sv
/*
  Testbench for the enable gating block: AXI4-Lite tasks and directed
  tests. Assumes the core model answers line 0 service.
*/
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] A_EN = iegate_pkg::OFS_ENABLE;
  localparam logic [7:0] A_CT = iegate_pkg::OFS_CTRL;
  localparam logic [7:0] A_RQ = iegate_pkg::OFS_REQ;
  localparam logic [7:0] A_ST = iegate_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] A_MK = iegate_pkg::OFS_IRQ_MASK;
  localparam logic [1:0] OK = iegate_pkg::RESP_OKAY;
  localparam logic [1:0] ER = iegate_pkg::RESP_SLVERR;
  logic clk, rst, awv, wv, arv, pin, svc;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [5:0] src, creq;
  logic [3:0] lat;
  logic awr, wr_r, bv, arr, rv, byp, irq;
  logic [1:0] br, rr;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  iegate_top DUT (
    .CLK_I(clk), .SYS_RST_I(rst),
    .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
    .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv),
    .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(1'b1), .EXT_LINE0_PIN_I(pin), .SRC_REQ_I(src),
    .EXT0_SERVICED_I(svc), .CORE_REQ_O(creq), .PRIO_BYPASS_O(byp),
    .IRQ_O(irq)
  );

  iegate_core_model core (
    .clk_i(clk), .rst_i(rst), .req_i(creq), .lat_i(lat),
    .ext0_serviced_o(svc)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Ready and response are registered, so the negedge value is the edge's
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic pa, pw, ta, tw, tk;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    tk = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    while (!tk) begin
      @(negedge clk);
      ta = pa && awr === 1'b1;
      tw = pw && wr_r === 1'b1;
      tk = bv === 1'b1;
      r = br;
      @(posedge clk);
      if (ta) begin
        awv <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wv <= 1'b0;
        pw = 1'b0;
      end
    end
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic pa, ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    pa = 1'b1;
    tr = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = pa && arr === 1'b1;
      tr = rv === 1'b1;
      d = rdat;
      r = rr;
      @(posedge clk);
      if (ta) begin
        arv <= 1'b0;
        pa = 1'b0;
      end
    end
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    rst = 1'b1;
    {awv, wv, arv, pin} = 4'h0;
    awa = 8'h0;
    ara = 8'h0;
    wd = 32'h0;
    src = 6'h0;
    lat = 4'hf;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(A_EN, 32'(iegate_pkg::ENABLE_RST) | 32'h40, OK);
    rd(A_MK, 32'(iegate_pkg::MASK_RST), OK);
    wr(A_EN, 32'hff, OK);
    rd(A_EN, 32'hff, OK);
    wr(A_EN, 32'hbf, OK);
    rd(A_EN, 32'hff, OK);
    wr(8'h04, 32'h1, ER);
    rd(8'h04, 32'h0, ER);
    @(posedge clk);
    src <= 6'h3e;
    pin <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      wr(A_EN, 32'h80 | (32'h1 << k), OK);
      cyc(6);
      chk({26'h0, creq}, 32'h1 << k);
    end
    wr(A_EN, 32'h3f, OK);
    cyc(6);
    chk({26'h0, creq}, 32'h0);
    wr(A_EN, 32'h80, OK);
    cyc(6);
    chk({26'h0, creq}, 32'h0);
    wr(A_EN, 32'hbf, OK);
    cyc(6);
    chk({26'h0, creq}, 32'h3f);
    wr(A_MK, 32'h02, OK);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    @(posedge clk);
    src <= 6'h0;
    pin <= 1'b0;
    cyc(6);
    wr(A_ST, 32'h3f, OK);
    rd(A_ST, 32'h0, OK);
    cyc(1);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    src <= 6'h04;
    cyc(6);
    chk({31'h0, irq}, 32'h0);
    @(posedge clk);
    src <= 6'h0;
    cyc(6);
    rd(A_ST, 32'h04, OK);
    wr(A_ST, 32'h04, OK);
    rd(A_ST, 32'h0, OK);
    wr(A_CT, 32'h80, OK);
    cyc(2);
    chk({31'h0, byp}, 32'h1);
    wr(A_CT, 32'h01, OK);
    wr(A_EN, 32'h81, OK);
    @(posedge clk);
    lat <= 4'h3;
    pin <= 1'b1;
    cyc(30);
    chk({31'h0, byp}, 32'h0);
    rd(A_ST, 32'h01, OK);
    rd(A_RQ, 32'h0, OK);
    wr(A_EN, 32'h01, OK);
    wr(A_RQ, 32'h1, OK);
    rd(A_RQ, 32'h1, OK);
    cyc(2);
    chk({26'h0, creq}, 32'h0);
    wr(A_RQ, 32'h0, OK);
    rd(A_RQ, 32'h0, OK);
    end_of_test();
  end
endmodule
